// *** design/mbh_pkg.sv ***
// shared constants for the bus halt and on-chip ram block
package mbh_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int RAM_AW = 8;
    localparam int RAM_DEPTH = 256;
    localparam int KEEP_BYTES = 32;
    localparam logic [ADDR_W-1:0] RAM_BASE = 16'h0000;
    localparam logic [ADDR_W-1:0] RAM_LAST = 16'h00FF;
    localparam logic [ADDR_W-1:0] KEEP_LAST = 16'h001F;
    localparam logic [7:0] RAM_PAGE = 8'h00;
    localparam logic [1:0] CLK_DIV = 2'h3;
    localparam logic [1:0] DIV_RST = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'hFFFF;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    typedef enum logic [1:0] {
        MBH_RUN,
        MBH_HALT,
        MBH_WAIT
    } mbh_state_t;
endpackage : mbh_pkg

// *** design/mbh_ram.sv ***
// 256 x 8 on-chip ram with registered read data
`timescale 1ns/1ps
module mbh_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule : mbh_ram

// *** design/mbh_core.sv ***
// bus control, halt handling and internal ram decode of the processor
`timescale 1ns/1ps
module mbh_core
    import mbh_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_halt_n,
    input wire logic i_irq_n,
    input wire logic i_ram_keep_enable,
    input wire logic i_standby_pwr,
    input wire logic i_cpu_req,
    input wire logic i_cpu_write,
    input wire logic [mbh_pkg::ADDR_W-1:0] i_cpu_addr,
    input wire logic [mbh_pkg::DATA_W-1:0] i_cpu_wdata,
    input wire logic i_cpu_instr_end,
    input wire logic i_cpu_wait_op,
    input wire logic [mbh_pkg::ADDR_W-1:0] i_cpu_next_pc,
    input wire logic [mbh_pkg::DATA_W-1:0] i_data_in,
    output logic [mbh_pkg::ADDR_W-1:0] o_addr,
    output logic [mbh_pkg::DATA_W-1:0] o_data_out,
    output logic o_data_oe,
    output logic o_read_not_write,
    output logic o_valid_address_strobe,
    output logic o_bus_released,
    output logic o_sys_clk_en,
    output logic o_cpu_stall,
    output logic o_irq_pending,
    output logic o_irq_take,
    output logic [mbh_pkg::DATA_W-1:0] o_cpu_rdata
);
    import mbh_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic halt_m_q, halt_s_q, irq_m_q, irq_s_q, keep_m_q, keep_s_q;
    logic sb_m_q, sb_s_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            {halt_m_q, halt_s_q, irq_m_q, irq_s_q} <= 4'hF;
            {keep_m_q, keep_s_q, sb_m_q, sb_s_q} <= 4'h0;
        end else begin
            halt_m_q <= i_halt_n;
            halt_s_q <= halt_m_q;
            irq_m_q <= i_irq_n;
            irq_s_q <= irq_m_q;
            keep_m_q <= i_ram_keep_enable;
            keep_s_q <= keep_m_q;
            sb_m_q <= i_standby_pwr;
            sb_s_q <= sb_m_q;
        end
    end

    // ----------------------------------------------------------------
    // clock divider
    // ----------------------------------------------------------------
    logic [1:0] div_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            div_q <= DIV_RST;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    wire tick = (div_q == CLK_DIV);
    assign o_sys_clk_en = tick;

    // ----------------------------------------------------------------
    // halt and wait state machine
    // ----------------------------------------------------------------
    mbh_state_t st_q, st_d;
    logic irq_lat_q;
    wire halt_req = !halt_s_q;
    // halt taken only at instruction end
    always_comb begin
        st_d = st_q;
        case (st_q)
            MBH_RUN: begin
                if (tick && i_cpu_instr_end && halt_req) begin
                    st_d = MBH_HALT;
                end else if (tick && i_cpu_instr_end && i_cpu_wait_op) begin
                    st_d = MBH_WAIT;
                end
            end
            // resume once halt seen high at a cycle edge
            MBH_HALT: begin
                if (tick && !halt_req) begin
                    st_d = MBH_RUN;
                end
            end
            MBH_WAIT: begin
                if (tick && irq_lat_q && !halt_req) begin
                    st_d = MBH_RUN;
                end
            end
            default: st_d = MBH_RUN;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q <= MBH_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    // latch while halted, serve only with halt high
    wire irq_take = tick && irq_lat_q && !halt_req && st_q != MBH_HALT
        && (st_q == MBH_WAIT || i_cpu_instr_end);
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_lat_q <= 1'b0;
        end else if (!irq_s_q) begin
            irq_lat_q <= 1'b1;
        end else if (irq_take) begin
            irq_lat_q <= 1'b0;
        end
    end
    assign o_irq_pending = irq_lat_q;
    assign o_irq_take = irq_take;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic in_ram(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:RAM_AW] == RAM_PAGE;
    endfunction
    wire running = (st_q == MBH_RUN);
    wire cyc_valid = running && i_cpu_req;
    // full decode of the low page
    wire ram_sel = cyc_valid && in_ram(i_cpu_addr);
    // no ram byte is writable in standby, as every write needs keep_s_q high
    wire standby = sb_s_q && !keep_s_q;
    wire keep_zone = i_cpu_addr <= KEEP_LAST;
    wire ram_we = ram_sel && i_cpu_write && tick && (!standby || keep_zone)
        && keep_s_q;
    assign o_cpu_stall = !running;

    logic [DATA_W-1:0] ram_rd;
    mbh_ram #(.AW(RAM_AW), .DW(DATA_W)) u_ram (
        .i_clk(i_clk),
        .i_we(ram_we),
        .i_addr(i_cpu_addr[RAM_AW-1:0]),
        .i_wdata(i_cpu_wdata),
        .o_rdata(ram_rd)
    );

    // ----------------------------------------------------------------
    // bus outputs
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] dout_q, rdata_q;
    logic oe_q, rnw_q, vma_q, ba_q, ram_q;
    wire oe_d = cyc_valid && (i_cpu_write || ram_sel);
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            addr_q <= ADDR_RST;
            {oe_q, vma_q, ba_q, ram_q} <= 4'h0;
            rnw_q <= 1'b1;
            dout_q <= DATA_RST;
        end else begin
            addr_q <= running ? i_cpu_addr : i_cpu_next_pc;
            oe_q <= oe_d;
            // write low only in a valid write cycle
            rnw_q <= !(cyc_valid && i_cpu_write);
            vma_q <= cyc_valid;
            ba_q <= !running;
            ram_q <= ram_sel;
            dout_q <= (ram_sel && !i_cpu_write) ? ram_rd : i_cpu_wdata;
        end
    end
    // external data ignored on ram cycles
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_q <= DATA_RST;
        end else begin
            rdata_q <= ram_q ? ram_rd : i_data_in;
        end
    end
    assign o_addr = addr_q;
    assign o_data_out = dout_q;
    assign o_data_oe = oe_q;
    assign o_read_not_write = rnw_q;
    assign o_valid_address_strobe = vma_q;
    assign o_bus_released = ba_q;
    assign o_cpu_rdata = rdata_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_halt_bus_idle: assert property (
        st_q == MBH_HALT |=> o_bus_released && !o_valid_address_strobe)
        else $error("bus not idle while halted");
    a_halt_rnw_high: assert property (
        !running |=> o_read_not_write)
        else $error("rnw low while halted");
    a_halt_drv_off: assert property (
        !running |=> !o_data_oe)
        else $error("data driven while halted");
    a_ram_drives: assert property (
        ram_sel |=> o_data_oe)
        else $error("ram access without drive");
    a_ram_window: assert property (
        cyc_valid |-> ram_sel == (i_cpu_addr <= RAM_LAST))
        else $error("ram select does not match window");
    a_vma_valid: assert property (
        o_valid_address_strobe |-> $past(cyc_valid))
        else $error("strobe without valid cycle");
    a_div_four: assert property (
        tick |=> !tick [*3] ##1 tick)
        else $error("clock enable not divide by four");
    a_irq_gate: assert property (
        irq_take |-> !halt_req)
        else $error("interrupt served during halt");
    a_keep_write: assert property (
        ram_we |-> $past(i_ram_keep_enable, 2))
        else $error("ram written while disabled");
    a_halt_entry: assert property (
        st_q == MBH_RUN && st_d == MBH_HALT |-> i_cpu_instr_end)
        else $error("halt mid instruction");
    c_halt: cover property (st_q == MBH_HALT ##1 st_q == MBH_RUN);
    c_wait: cover property (st_q == MBH_WAIT ##[1:40] irq_take);
    c_ram_wr: cover property (ram_we);
    c_ext_rd: cover property (cyc_valid && !ram_sel && !i_cpu_write);
endmodule : mbh_core

// *** dv/mbh_ext_mem_model.sv ***
// external memory model on the far side of the bus
`timescale 1ns/1ps
module mbh_ext_mem_model
    import mbh_pkg::*;
(
    input wire logic i_clk,
    input wire logic [mbh_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_read_not_write,
    input wire logic i_valid_address_strobe,
    output logic [mbh_pkg::DATA_W-1:0] o_data
);
    import mbh_pkg::*;
    logic [DATA_W-1:0] last_q = 8'h00;
    logic drive;
    // off in ram window, needs valid address
    assign drive = i_valid_address_strobe && i_read_not_write
        && (i_addr[15:8] != RAM_PAGE);
    // released bus toggles so no stale byte passes as data
    assign o_data = drive ? (i_addr[7:0] ^ i_addr[15:8]) : ~last_q;
    always @(posedge i_clk) begin
        last_q <= o_data;
    end
endmodule : mbh_ext_mem_model

// *** dv/tb.sv ***
// self-checking bench for the bus halt and on-chip ram block
`timescale 1ns/1ps
module tb;
    import mbh_pkg::*;
    // ----------
    // setup
    // ----------
    logic i_clk, i_rst_n, i_halt_n, i_irq_n, i_ram_keep_enable;
    logic i_standby_pwr, i_cpu_req, i_cpu_write, i_cpu_instr_end;
    logic i_cpu_wait_op, o_data_oe, o_read_not_write, o_bus_released;
    logic o_valid_address_strobe, o_sys_clk_en, o_cpu_stall;
    logic o_irq_pending, o_irq_take;
    logic [ADDR_W-1:0] i_cpu_addr, i_cpu_next_pc, o_addr;
    logic [DATA_W-1:0] i_cpu_wdata, i_data_in, o_data_out, o_cpu_rdata;
    logic [DATA_W-1:0] ext_data;
    int err_count = 0;
    int n_tests = 0;
    assign i_data_in = o_data_oe ? o_data_out : ext_data;
    mbh_core uut (.i_clk, .i_rst_n, .i_halt_n, .i_irq_n, .i_ram_keep_enable,
        .i_standby_pwr, .i_cpu_req, .i_cpu_write, .i_cpu_addr, .i_cpu_wdata,
        .i_cpu_instr_end, .i_cpu_wait_op, .i_cpu_next_pc, .i_data_in, .o_addr,
        .o_data_out, .o_data_oe, .o_read_not_write, .o_valid_address_strobe,
        .o_bus_released, .o_sys_clk_en, .o_cpu_stall, .o_irq_pending,
        .o_irq_take, .o_cpu_rdata);
    mbh_ext_mem_model ext (.i_clk, .i_addr(o_addr),
        .i_read_not_write(o_read_not_write),
        .i_valid_address_strobe(o_valid_address_strobe), .o_data(ext_data));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // ----------
    // helpers
    // ----------
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic end_sim();
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task automatic step(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step
    // request held four cycles so a tick always falls inside it
    task automatic bus(logic w, logic [15:0] a, logic [7:0] d);
        @(posedge i_clk);
        i_cpu_req <= 1'b1;
        i_cpu_write <= w;
        i_cpu_addr <= a;
        i_cpu_wdata <= d;
        step(4);
    endtask : bus
    task automatic idle();
        @(posedge i_clk);
        i_cpu_req <= 1'b0;
        i_cpu_write <= 1'b0;
    endtask : idle
    task automatic wait_rel(logic v);
        int n = 0;
        while (o_bus_released !== v && n < 20) begin
            step(1);
            n++;
        end
        chk("bus_released", v, o_bus_released);
    endtask : wait_rel
    // ----------
    // scenarios
    // ----------
    task automatic t_reset();
        step(10);
        chk("addr", ADDR_RST, o_addr);
        chk("rnw", 1'b1, o_read_not_write);
        chk("vma", 1'b0, o_valid_address_strobe);
        chk("released", 1'b0, o_bus_released);
        chk("oe", 1'b0, o_data_oe);
        chk("stall", 1'b0, o_cpu_stall);
    endtask : t_reset
    task automatic t_div();
        int c = 0;
        repeat (16) begin
            step(1);
            c += (o_sys_clk_en === 1'b1);
        end
        chk("tick count", 16'h0004, c[15:0]);
    endtask : t_div
    task automatic t_ram();
        logic [15:0] a[3] = '{16'h0000, 16'h001F, 16'h00FF};
        foreach (a[i]) begin
            bus(1'b1, a[i], a[i][7:0] ^ 8'h3C);
            chk("write rnw", 1'b0, o_read_not_write);
            chk("write data", a[i][7:0] ^ 8'h3C, o_data_out);
            bus(1'b0, a[i], 8'h00);
            chk("ram addr", a[i], o_addr);
            chk("ram oe", 1'b1, o_data_oe);
            chk("ram dout", a[i][7:0] ^ 8'h3C, o_data_out);
            chk("ram vma", 1'b1, o_valid_address_strobe);
            chk("ram rdata", a[i][7:0] ^ 8'h3C, o_cpu_rdata);
        end
        idle();
    endtask : t_ram
    task automatic t_ext();
        bus(1'b0, 16'h0100, 8'h00);
        chk("ext oe", 1'b0, o_data_oe);
        chk("ext vma", 1'b1, o_valid_address_strobe);
        chk("ext rdata", 8'h01, o_cpu_rdata);
        bus(1'b0, 16'hFF80, 8'h00);
        chk("ext rdata", 8'h7F, o_cpu_rdata);
        idle();
    endtask : t_ext
    task automatic t_keep();
        bus(1'b1, 16'h0010, 8'h5A);
        idle();
        i_ram_keep_enable <= 1'b0;
        i_standby_pwr <= 1'b1;
        step(3);
        bus(1'b1, 16'h0010, 8'hA5);
        idle();
        i_ram_keep_enable <= 1'b1;
        i_standby_pwr <= 1'b0;
        step(3);
        bus(1'b0, 16'h0010, 8'h00);
        chk("kept byte", 8'h5A, o_cpu_rdata);
        idle();
    endtask : t_keep
    task automatic t_wait();
        @(posedge i_clk);
        i_cpu_req <= 1'b1;
        i_cpu_write <= 1'b1;
        i_cpu_addr <= 16'h0100;
        i_cpu_instr_end <= 1'b1;
        i_cpu_wait_op <= 1'b1;
        wait_rel(1'b1);
        @(posedge i_clk);
        i_cpu_wait_op <= 1'b0;
        step(1);
        chk("wait vma", 1'b0, o_valid_address_strobe);
        chk("wait oe", 1'b0, o_data_oe);
        chk("wait rnw", 1'b1, o_read_not_write);
        chk("wait stall", 1'b1, o_cpu_stall);
        @(posedge i_clk);
        i_irq_n <= 1'b0;
        wait_rel(1'b0);
        @(posedge i_clk);
        i_irq_n <= 1'b1;
        step(10);
        chk("irq served", 1'b0, o_irq_pending);
    endtask : t_wait
    task automatic t_halt();
        int takes = 0;
        @(posedge i_clk);
        i_cpu_instr_end <= 1'b0;
        i_cpu_next_pc <= 16'h1234;
        i_cpu_req <= 1'b1;
        i_cpu_write <= 1'b1;
        i_cpu_addr <= 16'h0100;
        i_halt_n <= 1'b0;
        step(12);
        chk("released mid instr", 1'b0, o_bus_released);
        @(posedge i_clk);
        i_cpu_instr_end <= 1'b1;
        wait_rel(1'b1);
        @(posedge i_clk);
        i_irq_n <= 1'b0;
        repeat (8) begin
            step(1);
            takes += (o_irq_take === 1'b1);
        end
        chk("halt vma", 1'b0, o_valid_address_strobe);
        chk("halt rnw", 1'b1, o_read_not_write);
        chk("halt addr", 16'h1234, o_addr);
        chk("halt oe", 1'b0, o_data_oe);
        chk("halt stall", 1'b1, o_cpu_stall);
        chk("irq pending", 1'b1, o_irq_pending);
        chk("irq takes", 16'h0000, takes[15:0]);
        @(posedge i_clk);
        i_irq_n <= 1'b1;
        i_halt_n <= 1'b1;
        wait_rel(1'b0);
        step(10);
        chk("irq after halt", 1'b0, o_irq_pending);
        idle();
    endtask : t_halt
    initial begin
        i_rst_n = 1'b0;
        i_halt_n = 1'b1;
        i_irq_n = 1'b1;
        i_ram_keep_enable = 1'b1;
        i_standby_pwr = 1'b0;
        i_cpu_req = 1'b0;
        i_cpu_write = 1'b0;
        i_cpu_addr = 16'h0000;
        i_cpu_wdata = 8'h00;
        i_cpu_instr_end = 1'b0;
        i_cpu_wait_op = 1'b0;
        i_cpu_next_pc = 16'h0000;
        t_reset();
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        step(3);
        t_div();
        t_ram();
        t_ext();
        t_keep();
        t_wait();
        t_halt();
        end_sim();
    end
    initial begin
        #50000;
        err_count++;
        end_sim();
    end
endmodule : tb
